/* File: health_statistics_counters_tb_top.sv */
// self-checking bench for the health statistics counter bank
`timescale 1ns/1ps
module health_statistics_counters_tb_top;
  import hsc_pkg::*;
  logic           clk_sys, sys_rst, sq_issue, cq_post, operational, power_loss_pin;
  logic           nv_restore, log_rd, log_valid, busy;
  logic [15:0]    comp_temp, warning_temp_threshold;
  logic [1:0]     shutdown_notify_field;
  logic [8:0]     log_addr;
  logic [7:0]     log_data;
  hsc_io_evt_s    io_evt;
  hsc_integ_evt_s integ_evt;
  hsc_counters_s  nv_image, nv_snapshot;
  int             error_cnt, n_checks;
  hsc_counters #(.CYC_MIN(64'd10), .CYC_HOUR(64'd20)) i_hsc_counters (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .io_evt(io_evt), .sq_issue(sq_issue), .cq_post(cq_post),
    .integ_evt(integ_evt), .operational(operational), .comp_temp(comp_temp),
    .warning_temp_threshold(warning_temp_threshold), .shutdown_notify_field(shutdown_notify_field),
    .power_loss_pin(power_loss_pin), .nv_restore(nv_restore), .nv_image(nv_image),
    .nv_snapshot(nv_snapshot), .log_rd(log_rd), .log_addr(log_addr), .log_data(log_data),
    .log_valid(log_valid), .busy(busy));
  hsc_host_model i_hsc_host_model (.clk_sys(clk_sys), .io_evt(io_evt), .sq_issue(sq_issue),
    .cq_post(cq_post), .integ_evt(integ_evt), .log_rd(log_rd), .log_addr(log_addr),
    .log_data(log_data), .log_valid(log_valid));
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // read a log field and compare it
  task automatic look(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] v;
    i_hsc_host_model.rd(a, v);
    chk(128'(v), 128'(exp));
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // power failure pulse, then time for the unsafe count to land
  task automatic loss();
    @(posedge clk_sys);
    power_loss_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    power_loss_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_io();
    i_hsc_host_model.cmd(4'h8, 17'd8, 5'd12);
    i_hsc_host_model.cmd(4'h4, 17'd1000, 5'd9);
    i_hsc_host_model.cmd(4'h2, 17'd999, 5'd9);
    i_hsc_host_model.cmd(4'h3, 17'd500, 5'd9);
    repeat (4) @(posedge clk_sys);
    look(OFS_CMDS_RD, 32'h2);
    look(OFS_UNITS_RD, 32'h2);
    look(OFS_CMDS_WR, 32'h2);
    look(OFS_UNITS_WR, 32'h1);
  endtask
  task automatic t_busy();
    i_hsc_host_model.door(1'b1, 1'b0);
    #1;
    chk(128'(busy), 128'h1);
    repeat (11) @(posedge clk_sys);
    i_hsc_host_model.door(1'b0, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk(128'(busy), 128'h0);
    look(OFS_BUSY_MIN, 32'h1);
  endtask
  task automatic t_temp();
    @(posedge clk_sys);
    operational <= 1'b1;
    comp_temp <= 16'h0150;
    repeat (25) @(posedge clk_sys);
    comp_temp <= 16'h014F;
    repeat (20) @(posedge clk_sys);
    operational <= 1'b0;
    repeat (4) @(posedge clk_sys);
    look(OFS_POWER_HR, 32'h2);
    look(OFS_WARN_MIN, 32'h2);
  endtask
  task automatic t_unsafe();
    loss();
    look(OFS_UNSAFE, 32'h1);
    @(posedge clk_sys);
    shutdown_notify_field <= 2'h1;
    repeat (2) @(posedge clk_sys);
    shutdown_notify_field <= 2'h0;
    loss();
    look(OFS_UNSAFE, 32'h1);
    loss();
    look(OFS_UNSAFE, 32'h2);
  endtask
  task automatic t_restore();
    i_hsc_host_model.err(3'h7);
    i_hsc_host_model.err(3'h2);
    repeat (3) @(posedge clk_sys);
    look(OFS_MEDIA_ERR, 32'h4);
    @(posedge clk_sys);
    nv_image.cmds_rd <= 128'h0102;
    nv_image.units_rd.thou <= 128'h5;
    nv_image.units_rd.rem <= 10'h001;
    nv_restore <= 1'b1;
    @(posedge clk_sys);
    nv_restore <= 1'b0;
    repeat (3) @(posedge clk_sys);
    look(OFS_CMDS_RD, 32'h0102);
    look(OFS_UNITS_RD, 32'h6);
    look(9'h070, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset, scenarios, verdict
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    operational = 1'b0;
    power_loss_pin = 1'b0;
    nv_restore = 1'b0;
    comp_temp = 16'h0140;
    warning_temp_threshold = 16'h0150;
    shutdown_notify_field = 2'h0;
    nv_image = '0;
    error_cnt = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_io();
    t_busy();
    t_temp();
    t_unsafe();
    t_restore();
    test_done();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
endmodule

/* File: hsc_counters.sv */
// health statistics counter bank with log image byte read port
`timescale 1ns/1ps
module hsc_counters #(
  parameter longint unsigned CYC_MIN  = hsc_pkg::CYC_PER_MIN,
  parameter longint unsigned CYC_HOUR = hsc_pkg::CYC_PER_HOUR,
  parameter int unsigned     OUTS_W   = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire hsc_pkg::hsc_io_evt_s   io_evt,
  input  wire logic                   sq_issue,
  input  wire logic                   cq_post,
  input  wire hsc_pkg::hsc_integ_evt_s integ_evt,
  input  wire logic                   operational,
  input  wire logic [15:0]            comp_temp,
  input  wire logic [15:0]            warning_temp_threshold,
  input  wire logic [1:0]             shutdown_notify_field,
  input  wire logic                   power_loss_pin,
  input  wire logic                   nv_restore,
  input  wire hsc_pkg::hsc_counters_s nv_image,
  output hsc_pkg::hsc_counters_s      nv_snapshot,
  input  wire logic                   log_rd,
  input  wire logic [8:0]             log_addr,
  output logic [7:0]                  log_data,
  output logic                        log_valid,
  output logic                        busy
);
  import hsc_pkg::*;

  if (OUTS_W < 1 || OUTS_W > 32) begin : g_chk
    $error("hsc_counters: outstanding counter width out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // power loss pin synchroniser and edge detect

  logic pl_meta;
  logic pl_sync;
  logic pl_last;
  logic next_pl_meta;
  logic next_pl_sync;
  logic next_pl_last;
  logic power_lost;

  // two flops, then an edge detector on the second only
  always_comb begin
    next_pl_meta = power_loss_pin;
    next_pl_sync = pl_meta;
    next_pl_last = pl_sync;
  end

  // synchroniser and edge history registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pl_meta <= 1'b0;
      pl_sync <= 1'b0;
      pl_last <= 1'b0;
    end else begin
      pl_meta <= next_pl_meta;
      pl_sync <= next_pl_sync;
      pl_last <= next_pl_last;
    end
  end

  assign power_lost = pl_sync & ~pl_last;

  ////////////////////////////////////////////////////////////////////////////
  // shutdown notification tracking

  logic notified;
  logic next_notified;

  // a notification arms the flag until power actually drops
  always_comb begin
    next_notified = notified;
    if (shutdown_notify_field != 2'b00) begin
      next_notified = 1'b1;
    end else if (power_lost) begin
      next_notified = 1'b0;
    end
  end

  // notification flag register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      notified <= 1'b0;
    end else begin
      notified <= next_notified;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outstanding queued commands

  logic [OUTS_W-1:0] outs;
  logic [OUTS_W-1:0] next_outs;

  // issue by tail doorbell, retire by completion entry post
  always_comb begin
    next_outs = outs;
    unique case ({sq_issue, cq_post})
      2'b10:   next_outs = OUTS_W'(outs + 1'b1);
      2'b01:   next_outs = (outs != '0) ? OUTS_W'(outs - 1'b1) : outs;
      default: next_outs = outs;
    endcase
  end

  // outstanding count register; cast keeps any legal width in range
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      outs <= OUTS_W'(OUTS_RST);
    end else begin
      outs <= next_outs;
    end
  end

  assign busy = (outs != '0);

  ////////////////////////////////////////////////////////////////////////////
  // time bases

  logic busy_tick;
  logic power_tick;
  logic warn_tick;
  logic too_hot;

  // kelvin against kelvin, no conversion
  assign too_hot = (comp_temp >= warning_temp_threshold);

  // busy minutes run on the outstanding count
  hsc_time_accum #(
    .CYC_PER_UNIT (CYC_MIN),
    .CW           (40)
  ) u_busy_time (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .active  (busy),
    .tick    (busy_tick)
  );

  // power-on hours skip non-operational time
  hsc_time_accum #(
    .CYC_PER_UNIT (CYC_HOUR),
    .CW           (40)
  ) u_power_time (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .active  (operational),
    .tick    (power_tick)
  );

  // warning minutes while operational and hot
  hsc_time_accum #(
    .CYC_PER_UNIT (CYC_MIN),
    .CW           (40)
  ) u_warn_time (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .active  (operational & too_hot),
    .tick    (warn_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter bank

  hsc_counters_s cnt;
  hsc_counters_s next_cnt;
  logic [31:0]   io_units;
  logic [31:0]   add_rd;
  logic [31:0]   add_wr;
  logic [127:0]  integ_add;

  // scale block counts once for both directions
  assign io_units = hsc_units(io_evt.nblocks, io_evt.lba_shift);

  // compare and read feed read units; write uncorrectable feeds nothing
  assign add_rd = (io_evt.rd_done | io_evt.cmp_done) ? io_units : 32'h0;
  assign add_wr = (io_evt.wr_done & ~io_evt.wr_unc_done) ? io_units : 32'h0;

  // several integrity errors in one cycle each count
  assign integ_add = 128'(integ_evt.ecc) + 128'(integ_evt.crc) + 128'(integ_evt.tag);

  // restore from nonvolatile image wins over any event in that cycle
  always_comb begin
    next_cnt = cnt;
    if (nv_restore) begin
      next_cnt = nv_image;
    end else begin
      next_cnt.units_rd = hsc_acc_step(cnt.units_rd, add_rd);
      next_cnt.units_wr = hsc_acc_step(cnt.units_wr, add_wr);
      if (io_evt.rd_done | io_evt.cmp_done) begin
        next_cnt.cmds_rd = 128'(cnt.cmds_rd + 128'h1);
      end
      if (io_evt.wr_done) begin
        next_cnt.cmds_wr = 128'(cnt.cmds_wr + 128'h1);
      end
      if (busy_tick) begin
        next_cnt.busy_min = 128'(cnt.busy_min + 128'h1);
      end
      if (power_tick) begin
        next_cnt.power_hr = 128'(cnt.power_hr + 128'h1);
      end
      if (power_lost && !notified) begin
        next_cnt.unsafe = 128'(cnt.unsafe + 128'h1);
      end
      next_cnt.media_err = 128'(cnt.media_err + integ_add);
      if (warn_tick) begin
        next_cnt.warn_min = 32'(cnt.warn_min + 32'h1);
      end
    end
  end

  // counter bank register; reset zeros, restore brings saved values back
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // image handed to nonvolatile storage
  assign nv_snapshot = cnt;

  ////////////////////////////////////////////////////////////////////////////
  // log image byte read

  logic [127:0] field;
  logic [7:0]   next_log_data;
  logic         next_log_valid;

  // pick the 16-byte slot holding the addressed byte
  always_comb begin
    field = CNT_RST;
    unique case (log_addr[8:4])
      OFS_UNITS_RD[8:4]:  field = hsc_report(cnt.units_rd);
      OFS_UNITS_WR[8:4]:  field = hsc_report(cnt.units_wr);
      OFS_CMDS_RD[8:4]:   field = cnt.cmds_rd;
      OFS_CMDS_WR[8:4]:   field = cnt.cmds_wr;
      OFS_BUSY_MIN[8:4]:  field = cnt.busy_min;
      OFS_POWER_HR[8:4]:  field = cnt.power_hr;
      OFS_UNSAFE[8:4]:    field = cnt.unsafe;
      OFS_MEDIA_ERR[8:4]: field = cnt.media_err;
      OFS_WARN_MIN[8:4]:  field = (log_addr[3:0] < WARN_BYTES) ? 128'(cnt.warn_min) : CNT_RST;
      default:            field = CNT_RST;
    endcase
  end

  // least significant byte at the lowest address
  always_comb begin
    next_log_valid = log_rd;
    next_log_data  = log_data;
    if (log_rd) begin
      next_log_data = 8'(field >> {log_addr[3:0], 3'b000});
    end
  end

  // registered byte answer and its one-cycle valid
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      log_data  <= 8'h00;
      log_valid <= 1'b0;
    end else begin
      log_data  <= next_log_data;
      log_valid <= next_log_valid;
    end
  end

endmodule

/* File: hsc_counters_checker.sv */
// port assertions for the health statistics counter bank
`timescale 1ns/1ps
module hsc_counters_checker #(
  parameter longint unsigned CYC_MIN  = 64'd10,
  parameter longint unsigned CYC_HOUR = 64'd20
) (
  input wire logic                    clk_sys,
  input wire logic                    sys_rst,
  input wire hsc_pkg::hsc_io_evt_s    io_evt,
  input wire logic                    sq_issue,
  input wire logic                    cq_post,
  input wire hsc_pkg::hsc_integ_evt_s integ_evt,
  input wire logic                    operational,
  input wire logic                    power_loss_pin,
  input wire logic                    nv_restore,
  input wire hsc_pkg::hsc_counters_s  nv_image,
  input wire hsc_pkg::hsc_counters_s  nv_snapshot,
  input wire logic                    log_rd,
  input wire logic                    log_valid,
  input wire logic                    busy
);
  import hsc_pkg::*;
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // a read or compare completes with no restore in the way
  sequence s_rd_cmd;
    (io_evt.rd_done || io_evt.cmp_done) && !nv_restore;
  endsequence
  // three cycles out of the operational state
  sequence s_idle3;
    !operational [*3];
  endsequence
  a_rd_cmd_count: assert property (
    s_rd_cmd |=> nv_snapshot.cmds_rd == $past(nv_snapshot.cmds_rd) + 128'h1)
    else $error("read command count not bumped");
  a_rd_cmd_hold: assert property (
    !io_evt.rd_done && !io_evt.cmp_done && !nv_restore |=> $stable(nv_snapshot.cmds_rd))
    else $error("read command count moved");
  a_wr_cmd_count: assert property (
    io_evt.wr_done && !nv_restore |=> nv_snapshot.cmds_wr == $past(nv_snapshot.cmds_wr) + 128'h1)
    else $error("write command count not bumped");
  a_unc_no_units: assert property (
    (!io_evt.wr_done || io_evt.wr_unc_done) && !nv_restore && nv_snapshot.units_wr.pend == 32'h0
    |=> nv_snapshot.units_wr.pend == 32'h0) else $error("written units grew");
  a_media_count: assert property (
    !nv_restore |=> nv_snapshot.media_err
    == $past(nv_snapshot.media_err) + 128'($countones($past(integ_evt))))
    else $error("integrity error count wrong");
  a_busy_rise: assert property (
    sq_issue && !cq_post |=> busy) else $error("busy low with a command outstanding");
  a_idle_time_hold: assert property (
    s_idle3 ##0 !nv_restore |=> $stable(nv_snapshot.warn_min) && $stable(nv_snapshot.power_hr))
    else $error("time counted while not operational");
  a_unsafe_quiet: assert property (
    !power_loss_pin [*7] ##0 !nv_restore |=> $stable(nv_snapshot.unsafe))
    else $error("unsafe count moved without power loss");
  a_log_answer: assert property (
    log_rd |=> log_valid) else $error("log byte not answered");
  a_restore_load: assert property (
    nv_restore |=> nv_snapshot.cmds_rd == $past(nv_image.cmds_rd)
    && nv_snapshot.unsafe == $past(nv_image.unsafe)) else $error("restore not loaded");
endmodule
////////////////////////////////////////////////////////////////////////////
// attach to every counter bank instance
bind hsc_counters hsc_counters_checker #(.CYC_MIN(CYC_MIN), .CYC_HOUR(CYC_HOUR))
  i_hsc_counters_checker (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_evt(io_evt),
  .sq_issue(sq_issue), .cq_post(cq_post), .integ_evt(integ_evt), .operational(operational),
  .power_loss_pin(power_loss_pin), .nv_restore(nv_restore), .nv_image(nv_image),
  .nv_snapshot(nv_snapshot), .log_rd(log_rd), .log_valid(log_valid), .busy(busy));

/* File: hsc_host_model.sv */
// host side model: command completions, doorbells, error events, log reads
`timescale 1ns/1ps
module hsc_host_model (
  input  wire logic               clk_sys,
  output hsc_pkg::hsc_io_evt_s    io_evt,
  output logic                    sq_issue,
  output logic                    cq_post,
  output hsc_pkg::hsc_integ_evt_s integ_evt,
  output logic                    log_rd,
  output logic [8:0]              log_addr,
  input  wire logic [7:0]         log_data,
  input  wire logic               log_valid
);
  import hsc_pkg::*;
  // quiet bus at time zero
  initial begin
    io_evt = '0;
    sq_issue = 1'b0;
    cq_post = 1'b0;
    integ_evt = '0;
    log_rd = 1'b0;
    log_addr = 9'h000;
  end
  // one completed command: kind bits rd, cmp, wr, wr_unc
  task automatic cmd(input logic [3:0] kind, input logic [16:0] nb, input logic [4:0] sh);
    @(posedge clk_sys);
    io_evt <= {kind, nb, sh};
    @(posedge clk_sys);
    io_evt <= '0;
  endtask
  // tail doorbell issue and completion post pulses
  task automatic door(input logic iss, input logic post);
    @(posedge clk_sys);
    sq_issue <= iss;
    cq_post <= post;
    @(posedge clk_sys);
    sq_issue <= 1'b0;
    cq_post <= 1'b0;
  endtask
  // integrity error pulse, one bit per error kind
  task automatic err(input logic [2:0] e);
    @(posedge clk_sys);
    integ_evt <= e;
    @(posedge clk_sys);
    integ_evt <= '0;
  endtask
  // four log bytes, lowest address into the low byte
  task automatic rd(input logic [8:0] a, output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      log_rd <= 1'b1;
      log_addr <= 9'(a + 9'(i));
      @(posedge clk_sys);
      log_rd <= 1'b0;
      #1;
      v[8*i +: 8] = (log_valid === 1'b1) ? log_data : 8'hXX;
    end
  endtask
endmodule

/* File: hsc_pkg.sv */
// constants, carriers and helpers for the health statistics counter bank
package hsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint unsigned CLK_HZ       = 64'd10_000_000;
  localparam longint unsigned MINUTE_S     = 64'd60;
  localparam longint unsigned HOUR_S       = 64'd3600;
  localparam longint unsigned CYC_PER_MIN  = CLK_HZ * MINUTE_S;
  localparam longint unsigned CYC_PER_HOUR = CLK_HZ * HOUR_S;

  ////////////////////////////////////////////////////////////////////////////
  // data unit arithmetic
  localparam int unsigned UNIT_LOG2      = 9;       // 512-byte unit
  localparam logic [4:0]  UNIT_SHIFT     = 5'h09;
  localparam logic [31:0] UNITS_PER_REP  = 32'd1000;
  localparam logic [10:0] UNITS_PER_REP11 = 11'd1000;

  ////////////////////////////////////////////////////////////////////////////
  // log image byte offsets (fields are 16 bytes unless noted)
  localparam logic [8:0] OFS_UNITS_RD  = 9'h020;    // 47:32
  localparam logic [8:0] OFS_UNITS_WR  = 9'h030;    // 63:48
  localparam logic [8:0] OFS_CMDS_RD   = 9'h040;    // 79:64
  localparam logic [8:0] OFS_CMDS_WR   = 9'h050;    // 95:80
  localparam logic [8:0] OFS_BUSY_MIN  = 9'h060;    // 111:96
  localparam logic [8:0] OFS_POWER_HR  = 9'h080;    // 143:128
  localparam logic [8:0] OFS_UNSAFE    = 9'h090;    // 159:144
  localparam logic [8:0] OFS_MEDIA_ERR = 9'h0A0;    // 175:160
  localparam logic [8:0] OFS_WARN_MIN  = 9'h0C0;    // 195:192, 4 bytes
  localparam logic [3:0] WARN_BYTES    = 4'h4;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [127:0] CNT_RST  = 128'h0;
  localparam logic [15:0]  OUTS_RST = 16'h0;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        rd_done;      // read command completed
    logic        cmp_done;     // compare command completed
    logic        wr_done;      // write command completed
    logic        wr_unc_done;  // write uncorrectable completed
    logic [16:0] nblocks;      // logical blocks moved, one-based
    logic [4:0]  lba_shift;    // log2 of logical block size in bytes
  } hsc_io_evt_s;

  typedef struct packed {
    logic ecc;
    logic crc;
    logic tag;
  } hsc_integ_evt_s;

  typedef struct packed {
    logic [127:0] thou;        // whole thousands of units
    logic [9:0]   rem;         // units beyond the thousands
    logic [31:0]  pend;        // units not yet folded in
  } hsc_acc_s;

  typedef struct packed {
    hsc_acc_s     units_rd;
    hsc_acc_s     units_wr;
    logic [127:0] cmds_rd;
    logic [127:0] cmds_wr;
    logic [127:0] busy_min;
    logic [127:0] power_hr;
    logic [127:0] unsafe;
    logic [127:0] media_err;
    logic [31:0]  warn_min;
  } hsc_counters_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // blocks to 512-byte units; sizes under 512 treated as 512
  function automatic logic [31:0] hsc_units(input logic [16:0] nblocks,
                                            input logic [4:0]  lba_shift);
    logic [4:0] sh;
    sh = (lba_shift > UNIT_SHIFT) ? 5'(lba_shift - UNIT_SHIFT) : 5'h00;
    return 32'(32'(nblocks) << sh);
  endfunction

  // fold at most one thousand pending units per cycle, then add new units
  function automatic hsc_acc_s hsc_acc_step(input hsc_acc_s a,
                                            input logic [31:0] add);
    hsc_acc_s   r;
    logic [9:0] chunk;
    logic [10:0] sum;
    r     = a;
    chunk = (a.pend >= UNITS_PER_REP) ? UNITS_PER_REP[9:0] : a.pend[9:0];
    sum   = 11'(a.rem) + 11'(chunk);
    if (sum >= UNITS_PER_REP11) begin
      sum    = 11'(sum - UNITS_PER_REP11);
      r.thou = 128'(a.thou + 128'h1);
    end
    r.rem  = sum[9:0];
    r.pend = 32'(a.pend - 32'(chunk) + add);
    return r;
  endfunction

  // reported thousands, rounded up
  function automatic logic [127:0] hsc_report(input hsc_acc_s a);
    return (a.rem != 10'h000) ? 128'(a.thou + 128'h1) : a.thou;
  endfunction

endpackage

/* File: hsc_time_accum.sv */
// accumulator of qualified time that pulses once per whole time unit
`timescale 1ns/1ps
module hsc_time_accum #(
  parameter longint unsigned CYC_PER_UNIT = 64'd600_000_000,
  parameter int unsigned     CW           = 40
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic active,
  output logic      tick
);
  import hsc_pkg::*;

  if (CYC_PER_UNIT < 64'd1 || CW > 63 || CYC_PER_UNIT > (64'd1 << CW)) begin : g_chk
    $error("hsc_time_accum: cycle count does not fit counter");
  end

  localparam logic [CW-1:0] LAST = CW'(CYC_PER_UNIT - 64'd1);

  logic [CW-1:0] cyc;
  logic [CW-1:0] next_cyc;
  logic          next_tick;

  ////////////////////////////////////////////////////////////////////////////
  // count only while qualified; fractions are kept across idle gaps
  always_comb begin
    next_cyc  = cyc;
    next_tick = 1'b0;
    if (active) begin
      if (cyc == LAST) begin
        next_cyc  = '0;
        next_tick = 1'b1;
      end else begin
        next_cyc = CW'(cyc + 1'b1);
      end
    end
  end

  // register stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cyc  <= '0;
      tick <= 1'b0;
    end else begin
      cyc  <= next_cyc;
      tick <= next_tick;
    end
  end

endmodule
